//--- design/mps_top.sv
// Motor protection supervisor: current, thermal, speed, regen, timeout, watchdog and link front end.
// Assumes sensor words come from logic on clk_sys_in; header and CAN pins are asynchronous.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module mps_top #(
	parameter int unsigned TICK_CYC = mps_pkg::MS_TICK_CYC,
	parameter int unsigned WDT_CYCLES = mps_pkg::WDT_CYC,
	parameter int unsigned PWM_MIN = mps_pkg::PWM_MIN_CYC
) (
	// Clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              srst_in,
	// AHB-Lite slave
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic [31:0]            hrdata_out,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	// Sensors and controller
	input  wire mps_pkg::mps_sense_t sense_in,
	input  wire logic              cmd_valid_in,
	input  wire logic              kick_in,
	output mps_pkg::mps_drive_t    drive_out,
	output logic                   reboot_out,
	// Header pins and telemetry
	input  wire logic              hdr_rx_in,
	input  wire logic              tel_tx_in,
	output logic                   hdr_tx_out,
	output logic                   hdr_rx_sync_out,
	output mps_pkg::mps_proto_t    proto_out,
	// CAN connectors and controller
	input  wire logic              can_a_rx_in,
	input  wire logic              can_b_rx_in,
	input  wire logic              can_tx_in,
	output logic                   can_a_tx_out,
	output logic                   can_b_tx_out,
	output logic                   can_rx_out
);

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic        oc_latch, ot_latch, armed;
	logic        oc_err, ot_err, rebooted;
	logic [15:0] oc_limit, t_derate, t_max, c_derate, c_max, spd_max, spd_extr, vbus_max, timeout_ms;
	logic [15:0] coil_est;
	logic        derate, timed_out, regen_lim;
	logic        ahb_wr;
	logic [7:0]  ahb_addr;
	logic        wdt_fire;

	wire logic addr_phase = hsel_in && htrans_in[1] && hready_in;
	wire logic cur_over   = sense_in.cur > oc_limit;
	wire logic temp_over  = (sense_in.ctrl_temp > t_max) || (coil_est > c_max);
	wire logic wr_status  = ahb_wr && (ahb_addr == mps_pkg::OFS_STATUS);

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ahb_wr        <= 1'b0;
			ahb_addr      <= 8'h00;
			hreadyout_out <= 1'b0;
			hresp_out     <= 1'b0;
		end else begin
			ahb_wr        <= addr_phase && hwrite_in;
			ahb_addr      <= haddr_in[7:0];
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (addr_phase && !hwrite_in) begin
			unique case (haddr_in[7:0])
				mps_pkg::OFS_CTRL:   hrdata_out <= {29'h0, armed, ot_latch, oc_latch};
				mps_pkg::OFS_STATUS: hrdata_out <= {22'h0, armed, rebooted, proto_out, regen_lim,
					drive_out.brake, timed_out, derate, ot_err, oc_err};
				mps_pkg::OFS_OCLIM:  hrdata_out <= {16'h0, oc_limit};
				mps_pkg::OFS_TLIM:   hrdata_out <= {t_max, t_derate};
				mps_pkg::OFS_CLIM:   hrdata_out <= {c_max, c_derate};
				mps_pkg::OFS_SPEED:  hrdata_out <= {spd_extr, spd_max};
				mps_pkg::OFS_VBUS:   hrdata_out <= {16'h0, vbus_max};
				mps_pkg::OFS_TMO:    hrdata_out <= {16'h0, timeout_ms};
				mps_pkg::OFS_COIL:   hrdata_out <= {16'h0, coil_est};
				default:             hrdata_out <= 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			oc_latch   <= 1'b0;
			ot_latch   <= 1'b0;
			oc_limit   <= mps_pkg::RST_OC_LIMIT;
			t_derate   <= mps_pkg::RST_T_DERATE;
			t_max      <= mps_pkg::RST_T_MAX;
			c_derate   <= mps_pkg::RST_C_DERATE;
			c_max      <= mps_pkg::RST_C_MAX;
			spd_max    <= mps_pkg::RST_SPD_MAX;
			spd_extr   <= mps_pkg::RST_SPD_EXTR;
			vbus_max   <= mps_pkg::RST_VBUS_MAX;
			timeout_ms <= mps_pkg::RST_TIMEOUT_MS;
		end else if (ahb_wr) begin
			unique case (ahb_addr)
				mps_pkg::OFS_CTRL: begin
					oc_latch <= hwdata_in[mps_pkg::CTRL_OC_LATCH];
					ot_latch <= hwdata_in[mps_pkg::CTRL_OT_LATCH];
				end
				mps_pkg::OFS_OCLIM: oc_limit <= hwdata_in[15:0];
				mps_pkg::OFS_TLIM: begin
					t_derate <= hwdata_in[15:0];
					t_max    <= hwdata_in[31:16];
				end
				mps_pkg::OFS_CLIM: begin
					c_derate <= hwdata_in[15:0];
					c_max    <= hwdata_in[31:16];
				end
				mps_pkg::OFS_SPEED: begin
					spd_max  <= hwdata_in[15:0];
					spd_extr <= hwdata_in[31:16];
				end
				mps_pkg::OFS_VBUS: vbus_max   <= hwdata_in[15:0];
				mps_pkg::OFS_TMO:  timeout_ms <= hwdata_in[15:0];
				default: ;
			endcase
		end
	end

	// Arming: set by software, lost on watchdog reboot
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || wdt_fire) begin
			armed <= 1'b0;
		end else if (ahb_wr && ahb_addr == mps_pkg::OFS_CTRL) begin
			armed <= hwdata_in[mps_pkg::CTRL_ARM];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky error flags, write one to clear, set wins
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			oc_err   <= 1'b0;
			ot_err   <= 1'b0;
			rebooted <= 1'b0;
		end else begin
			oc_err   <= cur_over || (oc_err && !(wr_status && hwdata_in[mps_pkg::ST_OC_ERR]));
			ot_err   <= temp_over || (ot_err && !(wr_status && hwdata_in[mps_pkg::ST_OT_ERR]));
			rebooted <= wdt_fire || (rebooted && !(wr_status && hwdata_in[mps_pkg::ST_REBOOTED]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Millisecond tick and coil temperature model
	logic [31:0] tick_cnt;
	logic        tick;
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			tick_cnt <= 32'h0000_0000;
			tick     <= 1'b0;
		end else begin
			tick     <= tick_cnt == TICK_CYC - 1;
			tick_cnt <= (tick_cnt == TICK_CYC - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
		end
	end

	logic [16:0] coil_heat;
	logic [15:0] coil_cool;
	always_comb begin
		coil_cool = (coil_est > sense_in.ctrl_temp) ? (coil_est - sense_in.ctrl_temp) >> mps_pkg::COIL_COOL_SH
			: 16'h0000;
		coil_heat = {1'b0, coil_est - coil_cool} + {1'b0, sense_in.cur >> mps_pkg::COIL_HEAT_SH};
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			coil_est <= 16'h0000;
		end else if (tick) begin
			coil_est <= coil_heat[16] ? 16'hffff : coil_heat[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Voltage shaping chain
	logic [15:0] t_over, c_over, d_over, v_pred, v_der, v_spd, v_reg, spd_cut, next_volt;
	logic [23:0] der_prod;
	logic [7:0]  der_fac;
	always_comb begin
		v_pred   = (sense_in.pred_cur > oc_limit) ? drive_out.volt : sense_in.demand;
		t_over   = (sense_in.ctrl_temp > t_derate) ? sense_in.ctrl_temp - t_derate : 16'h0000;
		c_over   = (coil_est > c_derate) ? coil_est - c_derate : 16'h0000;
		d_over   = (t_over > c_over) ? t_over : c_over;
		der_fac  = (d_over > 16'h00ff) ? 8'h00 : 8'hff - d_over[7:0];
		der_prod = v_pred * der_fac;
		v_der    = (d_over == 16'h0000) ? v_pred : der_prod[23:8];
		spd_cut  = (sense_in.speed > spd_max) ? (sense_in.speed - spd_max) << mps_pkg::SPD_GAIN_SH : 16'h0000;
		v_spd    = (v_der > spd_cut) ? v_der - spd_cut : 16'h0000;
		v_reg    = (sense_in.vbus > vbus_max && v_spd < sense_in.speed) ? sense_in.speed : v_spd;
		next_volt = v_reg;
	end

	logic oc_block, ot_block, brake_req, next_en;
	always_comb begin
		oc_block  = cur_over || (oc_latch && oc_err);
		ot_block  = temp_over || (ot_latch && ot_err);
		brake_req = sense_in.speed > spd_extr;
		next_en   = armed && !timed_out && !oc_block && !ot_block && !brake_req && !wdt_fire;
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			drive_out <= '0;
			derate    <= 1'b0;
			regen_lim <= 1'b0;
		end else begin
			drive_out.bridge_en <= next_en;
			drive_out.brake     <= brake_req && !oc_block && !ot_block;
			drive_out.coast     <= !next_en && !(brake_req && !oc_block && !ot_block);
			drive_out.volt      <= next_en ? next_volt : 16'h0000;
			derate              <= (t_over != 16'h0000) || (c_over != 16'h0000);
			regen_lim           <= sense_in.vbus > vbus_max;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command timeout
	logic [15:0] tmo_cnt;
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			tmo_cnt   <= 16'h0000;
			timed_out <= 1'b1;
		end else if (cmd_valid_in) begin
			tmo_cnt   <= 16'h0000;
			timed_out <= 1'b0;
		end else if (tick && !timed_out) begin
			tmo_cnt   <= tmo_cnt + 16'h0001;
			timed_out <= tmo_cnt + 16'h0001 >= timeout_ms;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog: no kick for WDT_CYCLES resets the controller
	logic [31:0] wdt_cnt;
	logic [7:0]  rb_cnt;
	assign wdt_fire = wdt_cnt == WDT_CYCLES - 1;
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || kick_in || wdt_fire || reboot_out) begin
			wdt_cnt <= 32'h0000_0000;
		end else begin
			wdt_cnt <= wdt_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rb_cnt     <= 8'h00;
			reboot_out <= 1'b0;
		end else if (wdt_fire) begin
			rb_cnt     <= 8'(mps_pkg::REBOOT_CYC - 1);
			reboot_out <= 1'b1;
		end else begin
			rb_cnt     <= (rb_cnt != 8'h00) ? rb_cnt - 8'h01 : 8'h00;
			reboot_out <= rb_cnt != 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, change taken when stages two and three agree
	logic [2:0] rx_sync [3];
	logic       pin_stable [3];
	wire logic [2:0] pin_raw = {can_b_rx_in, can_a_rx_in, hdr_rx_in};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge clk_sys_in) begin
				if (srst_in) begin
					rx_sync[g]    <= 3'b111;
					pin_stable[g] <= 1'b1;
				end else begin
					rx_sync[g] <= {rx_sync[g][1:0], pin_raw[g]};
					if (rx_sync[g][1] == rx_sync[g][2]) begin
						pin_stable[g] <= rx_sync[g][2];
					end
				end
			end
		end
	endgenerate

	// Header and CAN pins
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			hdr_tx_out      <= 1'b1;
			hdr_rx_sync_out <= 1'b1;
			can_a_tx_out    <= 1'b1;
			can_b_tx_out    <= 1'b1;
			can_rx_out      <= 1'b1;
		end else begin
			hdr_tx_out      <= tel_tx_in;
			hdr_rx_sync_out <= pin_stable[0];
			can_a_tx_out    <= can_tx_in;
			can_b_tx_out    <= can_tx_in;
			can_rx_out      <= pin_stable[1] && pin_stable[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Protocol detection on pulse width of the top pin, or CAN activity
	logic [31:0] hi_cnt;
	logic        rx_prev;
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			hi_cnt    <= 32'h0000_0000;
			rx_prev   <= 1'b1;
			proto_out <= mps_pkg::MPS_PROTO_NONE;
		end else begin
			rx_prev <= pin_stable[0];
			hi_cnt  <= pin_stable[0] ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
			if (proto_out == mps_pkg::MPS_PROTO_NONE) begin
				if (!pin_stable[1] || !pin_stable[2]) begin
					proto_out <= mps_pkg::MPS_PROTO_CAN;
				end else if (rx_prev && !pin_stable[0] && hi_cnt != 32'h0000_0000) begin
					proto_out <= (hi_cnt >= PWM_MIN) ? mps_pkg::MPS_PROTO_PWM
						: mps_pkg::MPS_PROTO_SERIAL;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_oc_cut_bridge: assert property (sense_in.cur > oc_limit |=> !drive_out.bridge_en)
		else $error("bridge left on during over-current");
	a_oc_latch_hold: assert property (oc_latch && oc_err && !wr_status |=> !drive_out.bridge_en ##0 oc_err)
		else $error("latched over-current released");
	a_oc_nolatch_rel: assert property (!oc_latch && !cur_over && !temp_over && !ot_err && armed && !timed_out
		&& !brake_req && !wdt_fire |=> drive_out.bridge_en)
		else $error("non-latching over-current did not release");
	a_ot_cut_bridge: assert property (temp_over |=> !drive_out.bridge_en && ot_err)
		else $error("bridge left on during over-temperature");
	a_pred_hold: assert property (next_en && $past(next_en) && sense_in.pred_cur > oc_limit && d_over == 16'h0000
		&& spd_cut == 16'h0000 && sense_in.vbus <= vbus_max |=> drive_out.volt == $past(drive_out.volt))
		else $error("voltage raised against current prediction");
	a_derate_cut: assert property (derate && drive_out.bridge_en |-> drive_out.volt <= $past(sense_in.demand)
		|| $past(sense_in.vbus) > $past(vbus_max))
		else $error("derate did not reduce voltage");
	a_brake_extreme: assert property (brake_req && !oc_block && !ot_block |=> drive_out.brake && !drive_out.bridge_en)
		else $error("no brake at extreme speed");
	a_timeout_coast: assert property (timed_out && !brake_req |=> drive_out.coast && !drive_out.bridge_en)
		else $error("no coast after command timeout");
	a_resume_msg: assert property (cmd_valid_in |=> !timed_out)
		else $error("valid message did not clear timeout");
	a_wdt_reboot: assert property (wdt_fire |=> reboot_out && !armed [*2])
		else $error("watchdog did not reboot");
	a_can_fanout: assert property (##1 can_a_tx_out == $past(can_tx_in) && can_b_tx_out == $past(can_tx_in))
		else $error("CAN connectors not on one controller");

endmodule : mps_top

//--- design/mps_pkg.sv
// Constants, register map and carrier types of the motor protection supervisor.
// Assumes a 50 MHz system clock and one AHB-Lite master in front of the registers.
package mps_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned MS_TICK_NS     = 1000000;
	localparam int unsigned MS_TICK_CYC    = MS_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned WDT_TIME_NS    = 50000000;
	localparam int unsigned WDT_CYC        = WDT_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned PWM_MIN_NS     = 900000;
	localparam int unsigned PWM_MIN_CYC    = PWM_MIN_NS / CLK_PERIOD_NS;
	localparam int unsigned REBOOT_NS      = 320;
	localparam int unsigned REBOOT_CYC     = REBOOT_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_OCLIM  = 8'h08;
	localparam logic [7:0] OFS_TLIM   = 8'h0c;
	localparam logic [7:0] OFS_CLIM   = 8'h10;
	localparam logic [7:0] OFS_SPEED  = 8'h14;
	localparam logic [7:0] OFS_VBUS   = 8'h18;
	localparam logic [7:0] OFS_TMO    = 8'h1c;
	localparam logic [7:0] OFS_COIL   = 8'h20;

	// CTRL bits
	localparam int CTRL_OC_LATCH = 0;
	localparam int CTRL_OT_LATCH = 1;
	localparam int CTRL_ARM      = 2;
	// STATUS bits
	localparam int ST_OC_ERR   = 0;
	localparam int ST_OT_ERR   = 1;
	localparam int ST_DERATE   = 2;
	localparam int ST_TIMEOUT  = 3;
	localparam int ST_BRAKE    = 4;
	localparam int ST_REGEN    = 5;
	localparam int ST_PROTO_LO = 6;
	localparam int ST_REBOOTED = 8;
	localparam int ST_ARMED    = 9;

	// Reset values
	localparam logic [15:0] RST_OC_LIMIT   = 16'hc000;
	localparam logic [15:0] RST_T_DERATE   = 16'h5a00;
	localparam logic [15:0] RST_T_MAX      = 16'h6900;
	localparam logic [15:0] RST_C_DERATE   = 16'hc800;
	localparam logic [15:0] RST_C_MAX      = 16'hf000;
	localparam logic [15:0] RST_SPD_MAX    = 16'h8000;
	localparam logic [15:0] RST_SPD_EXTR   = 16'hc000;
	localparam logic [15:0] RST_VBUS_MAX   = 16'he000;
	localparam logic [15:0] RST_TIMEOUT_MS = 16'h0064;

	// Coil model shifts and speed-limiter gain
	localparam int COIL_HEAT_SH = 8;
	localparam int COIL_COOL_SH = 6;
	localparam int SPD_GAIN_SH  = 2;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		MPS_PROTO_NONE   = 2'b00,
		MPS_PROTO_SERIAL = 2'b01,
		MPS_PROTO_PWM    = 2'b11,
		MPS_PROTO_CAN    = 2'b10
	} mps_proto_t;

	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] pred_cur;
		logic [15:0] ctrl_temp;
		logic [15:0] speed;
		logic [15:0] vbus;
		logic [15:0] demand;
	} mps_sense_t;

	typedef struct packed {
		logic        bridge_en;
		logic        brake;
		logic        coast;
		logic [15:0] volt;
	} mps_drive_t;

endpackage : mps_pkg

//--- test/mps_host_model.sv
// Host model: drives the top header pin, CAN connector A (connector B held high) and command pulses.
// Assumes the bench owns the clock and calls frame() right after a reset release.
`timescale 1ns/1ps
module mps_host_model #(
	parameter int PW = 20
) (
	// Clock and control
	input  wire logic clk_in,
	input  wire logic keep_in,
	// Pins towards the device
	output logic      hdr_rx_out,
	output logic      can_a_out,
	output logic      can_b_out,
	output logic      cmd_valid_out
);
	logic [2:0] cnt = 3'h0;
	initial begin
		hdr_rx_out    = 1'b1;
		can_a_out     = 1'b1;
		can_b_out     = 1'b1;
		cmd_valid_out = 1'b0;
	end
	// One valid command every eight cycles while enabled
	always @(posedge clk_in) begin
		cnt           <= cnt + 3'h1;
		cmd_valid_out <= keep_in && cnt == 3'h0;
	end
	////////////////////////////////////////
	// Burst of one protocol: 0 serial, 1 PWM, 2 CAN
	task automatic frame(input int k);
		@(posedge clk_in);
		if (k == 2) begin
			can_a_out <= 1'b0;
			repeat (12) @(posedge clk_in);
			can_a_out <= 1'b1;
		end else begin
			repeat (k ? 2 * PW : 1) @(posedge clk_in);
			hdr_rx_out <= 1'b0;
			repeat (8) @(posedge clk_in);
			hdr_rx_out <= 1'b1;
		end
	endtask : frame
endmodule : mps_host_model

//--- test/motor_protection_supervisor_tb_top.sv
// Self-checking bench of the motor protection supervisor.
// Assumes shortened tick, watchdog and pulse-width counts set below.
`timescale 1ns/1ps
module motor_protection_supervisor_tb_top;
	typedef struct {int id; logic [31:0] e; logic [31:0] m;} mps_note_t;
	localparam int PW = 20;
	localparam logic [31:0] ARM = 32'h1 << mps_pkg::CTRL_ARM;
	logic                clk_sys_in = 1'b0;
	logic                srst_in    = 1'b1;
	logic                hsel = 1'b0, hwrite = 1'b0, keep = 1'b0, kick = 1'b0;
	logic                kick_en = 1'b0, tel = 1'b1, ctx = 1'b1, dph_rd = 1'b0;
	logic [1:0]          htrans = 2'h0;
	logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, v;
	logic [15:0]         dem = 16'h0400;
	logic                hready, hresp, reboot, hdr_tx, can_a_tx, can_b_tx, can_rx, hdr_rx_sync;
	logic                hdr_rx, can_a, can_b, cmd_v;
	mps_pkg::mps_sense_t sn = '0;
	mps_pkg::mps_drive_t drv;
	mps_pkg::mps_proto_t proto;
	mps_pkg::mps_proto_t pexp[3] = '{mps_pkg::MPS_PROTO_SERIAL, mps_pkg::MPS_PROTO_PWM, mps_pkg::MPS_PROTO_CAN};
	logic [7:0]          da[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
	logic [31:0]         de[9] = '{32'h0, 32'h1 << mps_pkg::ST_TIMEOUT, {16'h0, mps_pkg::RST_OC_LIMIT},
		{mps_pkg::RST_T_MAX, mps_pkg::RST_T_DERATE}, {mps_pkg::RST_C_MAX, mps_pkg::RST_C_DERATE},
		{mps_pkg::RST_SPD_EXTR, mps_pkg::RST_SPD_MAX}, {16'h0, mps_pkg::RST_VBUS_MAX},
		{16'h0, mps_pkg::RST_TIMEOUT_MS}, 32'h0};
	string               nm[4] = '{"drive", "protocol", "pins", "reboot width"};
	int                  fail_count = 0, comparisons = 0, seed = 32'ha1ac, hi_cnt = 0;
	mps_note_t           rd_q[$], out_q[$];

	initial begin
		forever #10 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) kick <= kick_en & 1'($random(seed));

	mps_top #(.TICK_CYC(10), .WDT_CYCLES(200), .PWM_MIN(PW)) dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .sense_in(sn), .cmd_valid_in(cmd_v), .kick_in(kick), .drive_out(drv),
		.reboot_out(reboot), .hdr_rx_in(hdr_rx), .tel_tx_in(tel), .hdr_tx_out(hdr_tx),
		.hdr_rx_sync_out(hdr_rx_sync), .proto_out(proto), .can_a_rx_in(can_a), .can_b_rx_in(can_b),
		.can_tx_in(ctx), .can_a_tx_out(can_a_tx), .can_b_tx_out(can_b_tx), .can_rx_out(can_rx));
	mps_host_model #(.PW(PW)) host (.clk_in(clk_sys_in), .keep_in(keep), .hdr_rx_out(hdr_rx),
		.can_a_out(can_a), .can_b_out(can_b), .cmd_valid_out(cmd_v));

	////////////////////////////////////////
	// Monitor: compares the oldest read note when read data shows, and every queued output note at each falling edge
	always @(posedge clk_sys_in) dph_rd <= hsel & htrans[1] & ~hwrite & hready;
	always @(negedge clk_sys_in) begin
		if (dph_rd === 1'b1 && rd_q.size() > 0) chk_rd(rd_q.pop_front());
		while (out_q.size() > 0) chk_out(out_q.pop_front());
	end
	task automatic report(input string s, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : report
	task automatic chk_rd(input mps_note_t n);
		report("read data", n.e & n.m, hrdata & n.m);
	endtask : chk_rd
	task automatic chk_out(input mps_note_t n);
		logic [31:0] g;
		case (n.id)
			0: g = {13'h0, drv};
			1: g = {30'h0, proto};
			2: g = {26'h0, hresp, hdr_rx_sync, hdr_tx, can_a_tx, can_b_tx, can_rx};
			default: g = hi_cnt;
		endcase
		report(nm[n.id], n.e & n.m, g & n.m);
	endtask : chk_out

	////////////////////////////////////////
	// Drivers
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : tick
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
	endtask : ahb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		rd_q.push_back('{0, e, m});
		ahb(1'b0, a, 32'h0);
	endtask : rd
	task automatic probe(input int id, input logic [31:0] e, m);
		out_q.push_back('{id, e, m});
	endtask : probe
	task automatic calm;
		sn <= '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h8000, dem};
	endtask : calm
	task automatic run_ok;
		probe(0, {13'h0, 3'b100, dem}, 32'h7ffff);
	endtask : run_ok
	task automatic print_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	initial begin
		#(20 * 20000);
		fail_count++;
		print_verdict;
	end

	////////////////////////////////////////
	// Scenarios
	initial begin
		calm;
		for (int k = 0; k < 3; k++) begin
			srst_in <= 1'b1;
			tick(12);
			srst_in <= 1'b0;
			fork
				host.frame(k);
				begin
					tick(10);
					if (k == 2) probe(2, 32'h0, 32'h1);
				end
			join
			tick(6);
			probe(1, {30'h0, pexp[k]}, 32'h3);
		end
		srst_in <= 1'b1;
		tick(12);
		srst_in <= 1'b0;
		kick_en <= 1'b1;
		for (int i = 0; i < 9; i++) rd(da[i], de[i], 32'hffffffff);
		ahb(1'b1, 8'h24, 32'hffffffff);
		rd(8'h24, 32'h0, 32'hffffffff);
		ahb(1'b1, mps_pkg::OFS_TMO, 32'h3);
		ahb(1'b1, mps_pkg::OFS_CTRL, ARM);
		dem = {2'b00, 14'($random(seed))} | 16'h0100;
		calm;
		keep <= 1'b1;
		tick(12);
		run_ok;
		for (int k = 0; k < 4; k++) begin
			ahb(1'b1, mps_pkg::OFS_CTRL, ARM | 32'(k / 2) << (k % 2 ? mps_pkg::CTRL_OT_LATCH : mps_pkg::CTRL_OC_LATCH));
			@(posedge clk_sys_in);
			if (k % 2)
				sn.ctrl_temp <= mps_pkg::RST_T_MAX + 16'h1;
			else
				sn.cur <= mps_pkg::RST_OC_LIMIT + 16'h1;
			tick(2);
			probe(0, 32'h10000, 32'h5ffff);
			calm;
			tick(2);
			probe(0, k / 2 ? 32'h10000 : {13'h0, 3'b100, dem}, 32'h5ffff);
			rd(mps_pkg::OFS_STATUS, 32'h1 << (k % 2), 32'h1 << (k % 2));
			ahb(1'b1, mps_pkg::OFS_STATUS, 32'h1 << (k % 2));
			tick(2);
			run_ok;
			rd(mps_pkg::OFS_STATUS, 32'h0, 32'h1 << (k % 2));
		end
		sn.ctrl_temp <= mps_pkg::RST_T_DERATE + 16'h20;
		tick(3);
		probe(0, {13'h0, 3'b100, 16'((32'(dem) * 32'd223) >> 8)}, 32'h7ffff);
		rd(mps_pkg::OFS_STATUS, 32'h1 << mps_pkg::ST_DERATE, 32'h1 << mps_pkg::ST_DERATE);
		calm;
		tick(3);
		run_ok;
		ahb(1'b1, mps_pkg::OFS_CLIM, 32'hffff0001);
		tick(30);
		rd(mps_pkg::OFS_STATUS, 32'h1 << mps_pkg::ST_DERATE, 32'h1 << mps_pkg::ST_DERATE);
		ahb(1'b1, mps_pkg::OFS_CLIM, {mps_pkg::RST_C_MAX, mps_pkg::RST_C_DERATE});
		rd(mps_pkg::OFS_STATUS, 32'h0, 32'h1 << mps_pkg::ST_DERATE);
		sn.pred_cur <= mps_pkg::RST_OC_LIMIT + 16'h1;
		sn.demand   <= dem ^ 16'h0080;
		tick(3);
		run_ok;
		calm;
		sn.speed <= mps_pkg::RST_SPD_MAX + 16'h3;
		tick(3);
		probe(0, {13'h0, 3'b100, dem - 16'hc}, 32'h7ffff);
		sn.speed <= mps_pkg::RST_SPD_EXTR + 16'h1;
		tick(3);
		probe(0, 32'h20000, 32'h6ffff);
		rd(mps_pkg::OFS_STATUS, 32'h1 << mps_pkg::ST_BRAKE, 32'h1 << mps_pkg::ST_BRAKE);
		sn.speed <= 16'h4000;
		sn.vbus  <= mps_pkg::RST_VBUS_MAX + 16'h1;
		tick(3);
		probe(0, {13'h0, 3'b100, 16'h4000}, 32'h7ffff);
		rd(mps_pkg::OFS_STATUS, 32'h1 << mps_pkg::ST_REGEN, 32'h1 << mps_pkg::ST_REGEN);
		calm;
		keep <= 1'b0;
		tick(50);
		probe(0, 32'h10000, 32'h5ffff);
		rd(mps_pkg::OFS_STATUS, 32'h1 << mps_pkg::ST_TIMEOUT, 32'h1 << mps_pkg::ST_TIMEOUT);
		keep <= 1'b1;
		tick(12);
		run_ok;
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			tel <= v[0];
			ctx <= v[1];
			tick(1);
			probe(2, {26'h0, 1'b0, 1'b1, v[0], v[1], v[1], 1'b1}, 32'h3f);
		end
		kick_en <= 1'b0;
		for (int i = 0; i < 400 && reboot !== 1'b1; i++) @(negedge clk_sys_in);
		while (reboot === 1'b1 && hi_cnt < 40) begin
			hi_cnt++;
			@(negedge clk_sys_in);
		end
		probe(3, 32'd16, 32'hff);
		@(posedge clk_sys_in);
		kick_en <= 1'b1;
		rd(mps_pkg::OFS_STATUS, 32'h1 << mps_pkg::ST_REBOOTED, 32'h3 << mps_pkg::ST_REBOOTED);
		ahb(1'b1, mps_pkg::OFS_STATUS, 32'h1 << mps_pkg::ST_REBOOTED);
		ahb(1'b1, mps_pkg::OFS_CTRL, ARM);
		tick(12);
		run_ok;
		tick(2);
		print_verdict;
	end
endmodule : motor_protection_supervisor_tb_top
